//--- hw/sbff_cfg.svh
/*
 * Constants of the shared buffer frame forwarder: register offsets, field positions, reset values.
 * Assumes inclusion by bare name from the package; holds definitions only.
 */
`ifndef SBFF_CFG_SVH
`define SBFF_CFG_SVH

// ****************************************
// Sizes
// ****************************************
`define SBFF_PORTS_MAX 15
`define SBFF_PKT_WORDS 13'h1740
`define SBFF_WORD_BYTES 176
`define SBFF_REF_W 8

// ****************************************
// Register offsets
// ****************************************
`define SBFF_OFS_FREE 9'h000
`define SBFF_OFS_SEL 9'h004
`define SBFF_OFS_PUSE 9'h008
`define SBFF_OFS_TOTTD 9'h00C
`define SBFF_OFS_TOTPS 9'h010
`define SBFF_OFS_TDCNT 9'h014
`define SBFF_GRP_TDLIM 3'h4
`define SBFF_GRP_PAUSE 3'h5
`define SBFF_GRP_MODE 3'h6
`define SBFF_GRP_DCNT 3'h7

// ****************************************
// Fields and reset values
// ****************************************
`define SBFF_PS_STOP_LSB 16
`define SBFF_IMODE_DROP 2'h0
`define SBFF_IMODE_FC 2'h1
`define SBFF_IMODE_PFC 2'h2
`define SBFF_TOTTD_RST 13'h0000
`define SBFF_TOTPS_RST 13'h0000
`define SBFF_TDLIM_RST 13'h1740
`define SBFF_PSSTART_RST 13'h0400
`define SBFF_PSSTOP_RST 13'h0200
`define SBFF_MODE_RST 7'h00

`endif

//--- hw/sbff_pkg.sv
/*
 * Types of the shared buffer frame forwarder.
 * Assumes the constants header is on the include path.
 */
`include "sbff_cfg.svh"
package sbff_pkg;
	typedef struct packed {
		logic [`SBFF_PORTS_MAX-1:0] dest_set;
		logic [7:0] cpu_queue_mask;
		logic [1:0] mirror;
		logic learn_all;
		logic drop_frame;
		logic [1:0] drop_precedence;
		logic [2:0] qos;
		logic [2:0] pcp;
		logic [2:0] class_of_service_id;
		logic [2:0] tc;
		logic super_priority_flag;
		logic [2:0] queue_group;
		logic [2:0] oam_type;
	} sbff_result_t;

	typedef struct packed {
		logic [3:0] port;
		logic [5:0] words;
		sbff_result_t res;
	} sbff_arr_t;

	typedef struct packed {
		logic [5:0] words;
		sbff_result_t res;
	} sbff_desc_t;

	typedef struct packed {
		logic [3:0] port;
		logic [5:0] words;
	} sbff_rel_t;

	typedef struct packed {
		logic [3:0] egress;
		logic [3:0] src;
		logic [`SBFF_REF_W-1:0] ref_addr;
		logic [5:0] words;
		logic [2:0] qos;
		logic [1:0] drop_precedence;
		logic super_priority_flag;
		logic [2:0] queue_group;
	} sbff_enq_t;

	typedef struct packed {
		logic [3:0] src;
		logic [`SBFF_PORTS_MAX-1:0] mask;
	} sbff_disc_t;

	// Gray along select, load, process
	typedef enum logic [1:0] {
		SBFF_SEL = 2'b00,
		SBFF_LOAD = 2'b01,
		SBFF_PROC = 2'b11
	} sbff_fsm_t;
endpackage

//--- hw/sbff_desc_mem.sv
/*
 * Descriptor memory holding the ingress queue entries, one write and one registered read port.
 * Assumes one clock; contents are undefined until written.
 */
`timescale 1ns/100ps
module sbff_desc_mem #(
	parameter int WIDTH = 8,
	parameter int AW = 8
) (
	// Clock
	input wire logic clk_i,
	// Write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	// Read port
	input wire logic re_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_ff [0:(1<<AW)-1];

	initial begin
		if (WIDTH < 1 || AW < 1) begin
			$error("sbff_desc_mem: bad geometry");
		end
	end

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
		if (re_i) begin
			rdata_o <= mem_ff[raddr_i];
		end
	end
endmodule

//--- hw/sbff_top.sv
/*
 * Buffer control and frame forwarder: admits frames into the shared memory, queues their
 * descriptors per ingress port, and turns each head frame into egress references or discards.
 * Assumes analyzer results, releases and congestion flags are synchronous to clk_i.
 */
`timescale 1ns/100ps
module sbff_top #(
	parameter int NPORTS = 15,
	parameter int QAW = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [8:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Frame arrival with analyzer result
	input wire logic arr_valid_i,
	input wire sbff_pkg::sbff_arr_t arr_i,
	output logic arr_ready_o,
	// Word release from the egress side
	input wire logic rel_valid_i,
	input wire sbff_pkg::sbff_rel_t rel_i,
	// Egress reference output
	output logic enq_valid_o,
	output sbff_pkg::sbff_enq_t enq_o,
	input wire logic enq_ready_i,
	// Congestion per egress port
	input wire logic [NPORTS-1:0] cong_i,
	// Discards and pause requests
	output logic disc_valid_o,
	output sbff_pkg::sbff_disc_t disc_o,
	output logic tail_drop_o,
	output logic [NPORTS-1:0] pause_o
);
	localparam int QDEPTH = 1 << QAW;
	localparam int MAW = 4 + QAW;
	localparam int PM = `SBFF_PORTS_MAX;

	initial begin
		if (NPORTS < 1 || NPORTS > PM || QAW < 1 || MAW > `SBFF_REF_W) begin
			$error("sbff_top: unsupported NPORTS or QAW");
		end
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		sbff_pkg::sbff_fsm_t fsm;
		logic [3:0] rr_ptr;
		logic [2:0] credit;
		logic [3:0] src;
		logic cur_egr;
		sbff_pkg::sbff_desc_t desc;
		logic [PM-1:0] rem;
		logic sw_any;
		logic dc_any;
		logic [12:0] free;
		logic [NPORTS-1:0][12:0] usage;
		logic [NPORTS-1:0][QAW-1:0] head;
		logic [NPORTS-1:0][QAW-1:0] tail;
		logic [NPORTS-1:0][QAW:0] cnt;
		logic [NPORTS-1:0] pend_v;
		logic [NPORTS-1:0][PM-1:0] pend_mask;
		logic [NPORTS-1:0] pend_sw;
		logic [NPORTS-1:0] pend_dc;
		logic [NPORTS-1:0][3:0] blk_egr;
		logic [NPORTS-1:0] pause;
		logic [3:0] sel;
		logic [12:0] tot_td;
		logic [12:0] tot_ps;
		logic [NPORTS-1:0][12:0] td_lim;
		logic [NPORTS-1:0][12:0] ps_start;
		logic [NPORTS-1:0][12:0] ps_stop;
		logic [NPORTS-1:0][6:0] mode;
		logic [NPORTS-1:0][15:0] dcnt;
		logic [15:0] tdcnt;
		logic ack;
		logic [31:0] rdata;
		logic enq_v;
		sbff_pkg::sbff_enq_t enq;
		logic disc_v;
		sbff_pkg::sbff_disc_t disc;
		logic td;
	} sbff_st_t;

	function automatic sbff_st_t rst_val();
		sbff_st_t s;
		s = '0;
		s.fsm = sbff_pkg::SBFF_SEL;
		s.free = `SBFF_PKT_WORDS;
		s.tot_td = `SBFF_TOTTD_RST;
		s.tot_ps = `SBFF_TOTPS_RST;
		for (int p = 0; p < NPORTS; p++) begin
			s.td_lim[p] = `SBFF_TDLIM_RST;
			s.ps_start[p] = `SBFF_PSSTART_RST;
			s.ps_stop[p] = `SBFF_PSSTOP_RST;
			s.mode[p] = `SBFF_MODE_RST;
		end
		return s;
	endfunction

	localparam sbff_st_t ST_RST = rst_val();

	function automatic logic [12:0] ext(input logic [5:0] w);
		return {7'h00, w};
	endfunction

	function automatic logic [3:0] lowest(input logic [PM-1:0] m);
		logic [3:0] r;
		r = 4'h0;
		for (int i = PM - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [4:0] pick(input logic [NPORTS-1:0] el, input logic [3:0] ptr);
		logic [4:0] r;
		int j;
		r = 5'h00;
		for (int i = 1; i <= NPORTS; i++) begin
			j = (int'(ptr) + i) % NPORTS;
			if (el[j] && !r[4]) begin
				r = {1'b1, 4'(j)};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction

	sbff_st_t st_ff;
	sbff_st_t nxt_st;
	logic [1:0] rst_sync_ff;
	logic rst_n;
	logic mem_we;
	logic mem_re;
	logic [MAW-1:0] mem_waddr;
	logic [MAW-1:0] mem_raddr;
	sbff_pkg::sbff_desc_t mem_wdata;
	sbff_pkg::sbff_desc_t mem_rdata;
	logic [12:0] used;
	logic [NPORTS-1:0] elig;
	logic [4:0] pk;
	logic alloc;
	logic fwd_free;
	logic ing_inc;
	logic blk_now;
	logic [PM-1:0] cgv;
	logic [PM-1:0] dmv;
	logic [PM-1:0] dropm;
	logic [PM-1:0] rem2;
	logic [3:0] e;
	logic [3:0] ap;
	logic [31:0] wv;
	logic [3:0] ri;
	logic slot;

	// ****************************************
	// Reset release and descriptor memory
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'b00;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];

	sbff_desc_mem #(.WIDTH($bits(sbff_pkg::sbff_desc_t)), .AW(MAW)) u_mem (
		.clk_i(clk_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.re_i(mem_re),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rdata)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;
		nxt_st.disc_v = 1'b0;
		nxt_st.disc.mask = '0;
		nxt_st.td = 1'b0;
		used = `SBFF_PKT_WORDS - st_ff.free;
		ap = arr_i.port;
		mem_we = 1'b0;
		mem_re = 1'b0;
		mem_waddr = {ap, st_ff.tail[ap]};
		mem_raddr = '0;
		mem_wdata = {arr_i.words, arr_i.res};
		alloc = 1'b0;
		fwd_free = 1'b0;
		ing_inc = 1'b0;
		blk_now = 1'b0;
		cgv = PM'(cong_i);
		dmv = '0;
		dropm = '0;
		rem2 = st_ff.rem;
		e = 4'h0;
		pk = 5'h00;
		slot = !st_ff.enq_v || enq_ready_i;
		if (enq_ready_i) begin
			nxt_st.enq_v = 1'b0;
		end
		// Buffer admission; a refused frame is dropped whole
		if (arr_valid_i) begin
			if (ap >= 4'(NPORTS) || st_ff.cnt[ap] == (QAW+1)'(QDEPTH)
					|| ext(arr_i.words) > st_ff.free
					|| (st_ff.usage[ap] + ext(arr_i.words) > st_ff.td_lim[ap] && used >= st_ff.tot_td)) begin
				nxt_st.td = 1'b1;
				nxt_st.tdcnt = st_ff.tdcnt + 16'h0001;
			end else begin
				alloc = 1'b1;
				mem_we = 1'b1;
				nxt_st.tail[ap] = st_ff.tail[ap] + 1'b1;
			end
		end
		// Weighted round robin; a queue blocked on a congested port is skipped
		for (int p = 0; p < NPORTS; p++) begin
			elig[p] = st_ff.cnt[p] != '0 && !(st_ff.pend_v[p] && cgv[st_ff.blk_egr[p]]);
		end
		for (int p = 0; p < PM; p++) begin
			dmv[p] = st_ff.mode[st_ff.src][4:3] == `SBFF_IMODE_DROP || st_ff.desc.res.drop_frame;
			if (p < NPORTS) begin
				dmv[p] = dmv[p] || st_ff.mode[p][5];
			end
		end
		case (st_ff.fsm)
			sbff_pkg::SBFF_SEL: begin
				if (elig[st_ff.rr_ptr] && st_ff.credit != 3'h0) begin
					pk = {1'b1, st_ff.rr_ptr};
					nxt_st.credit = st_ff.credit - 3'h1;
				end else begin
					pk = pick(elig, st_ff.rr_ptr);
					nxt_st.credit = st_ff.mode[pk[3:0]][2:0];
				end
				if (pk[4]) begin
					nxt_st.rr_ptr = pk[3:0];
					nxt_st.src = pk[3:0];
					mem_re = 1'b1;
					mem_raddr = {pk[3:0], st_ff.head[pk[3:0]]};
					nxt_st.fsm = sbff_pkg::SBFF_LOAD;
				end else begin
					nxt_st.credit = st_ff.credit;
				end
			end
			sbff_pkg::SBFF_LOAD: begin
				nxt_st.desc = mem_rdata;
				nxt_st.cur_egr = st_ff.mode[st_ff.src][6];
				if (st_ff.pend_v[st_ff.src]) begin
					nxt_st.rem = st_ff.pend_mask[st_ff.src];
					nxt_st.sw_any = st_ff.pend_sw[st_ff.src];
					nxt_st.dc_any = st_ff.pend_dc[st_ff.src];
				end else begin
					nxt_st.rem = mem_rdata.res.dest_set & PM'((1 << NPORTS) - 1);
					nxt_st.sw_any = 1'b0;
					nxt_st.dc_any = 1'b0;
				end
				nxt_st.fsm = sbff_pkg::SBFF_PROC;
			end
			sbff_pkg::SBFF_PROC: begin
				if (st_ff.cur_egr) begin
					e = lowest(st_ff.rem);
					if (st_ff.rem != '0 && cgv[e] && dmv[e]) begin
						rem2[e] = 1'b0;
						nxt_st.disc_v = 1'b1;
						nxt_st.disc.mask[e] = 1'b1;
						nxt_st.dcnt[e] = st_ff.dcnt[e] + 16'h0001;
						nxt_st.dc_any = 1'b1;
					end
				end else begin
					dropm = st_ff.rem & cgv & dmv;
					rem2 = st_ff.rem & ~dropm;
					if (dropm != '0) begin
						nxt_st.disc_v = 1'b1;
						nxt_st.disc.mask = dropm;
						nxt_st.dc_any = 1'b1;
					end
					e = lowest(rem2);
				end
				nxt_st.disc.src = st_ff.src;
				if (rem2 != '0 && rem2[e] && cgv[e]) begin
					blk_now = 1'b1;
				end else if (rem2 != '0 && rem2[e] && slot) begin
					rem2[e] = 1'b0;
					nxt_st.sw_any = 1'b1;
					nxt_st.enq_v = 1'b1;
					nxt_st.enq.egress = e;
					nxt_st.enq.src = st_ff.src;
					nxt_st.enq.ref_addr = `SBFF_REF_W'({st_ff.src, st_ff.head[st_ff.src]});
					nxt_st.enq.words = st_ff.desc.words;
					nxt_st.enq.qos = st_ff.desc.res.qos;
					nxt_st.enq.drop_precedence = st_ff.desc.res.drop_precedence;
					nxt_st.enq.super_priority_flag = st_ff.desc.res.super_priority_flag;
					nxt_st.enq.queue_group = st_ff.desc.res.queue_group;
				end
				nxt_st.rem = rem2;
				if (blk_now) begin
					nxt_st.pend_v[st_ff.src] = 1'b1;
					nxt_st.pend_mask[st_ff.src] = rem2;
					nxt_st.pend_sw[st_ff.src] = nxt_st.sw_any;
					nxt_st.pend_dc[st_ff.src] = nxt_st.dc_any;
					nxt_st.blk_egr[st_ff.src] = e;
					nxt_st.fsm = sbff_pkg::SBFF_SEL;
				end else if (rem2 == '0) begin
					nxt_st.pend_v[st_ff.src] = 1'b0;
					nxt_st.head[st_ff.src] = st_ff.head[st_ff.src] + 1'b1;
					fwd_free = !nxt_st.sw_any;
					ing_inc = !st_ff.cur_egr && !nxt_st.sw_any && nxt_st.dc_any;
					nxt_st.fsm = sbff_pkg::SBFF_SEL;
				end
			end
			default: begin
				nxt_st.fsm = sbff_pkg::SBFF_SEL;
			end
		endcase
		if (ing_inc) begin
			nxt_st.dcnt[st_ff.src] = st_ff.dcnt[st_ff.src] + 16'h0001;
		end
		// Word accounting from allocation, release and frames that leave with no switched copy
		nxt_st.free = st_ff.free - (alloc ? ext(arr_i.words) : 13'h0000)
			+ (rel_valid_i ? ext(rel_i.words) : 13'h0000) + (fwd_free ? ext(st_ff.desc.words) : 13'h0000);
		for (int p = 0; p < NPORTS; p++) begin
			nxt_st.usage[p] = st_ff.usage[p] + ((alloc && ap == 4'(p)) ? ext(arr_i.words) : 13'h0000)
				- ((rel_valid_i && rel_i.port == 4'(p)) ? ext(rel_i.words) : 13'h0000)
				- ((fwd_free && st_ff.src == 4'(p)) ? ext(st_ff.desc.words) : 13'h0000);
			nxt_st.cnt[p] = st_ff.cnt[p] + (((alloc && ap == 4'(p))) ? (QAW+1)'(1) : (QAW+1)'(0))
				- ((rem2 == '0 && !blk_now && st_ff.fsm == sbff_pkg::SBFF_PROC && st_ff.src == 4'(p))
				? (QAW+1)'(1) : (QAW+1)'(0));
			// Pause with hysteresis, only on flow-controlled ports
			if (st_ff.mode[p][4:3] == `SBFF_IMODE_DROP) begin
				nxt_st.pause[p] = 1'b0;
			end else if (st_ff.usage[p] >= st_ff.ps_start[p] && used >= st_ff.tot_ps) begin
				nxt_st.pause[p] = 1'b1;
			end else if (st_ff.usage[p] <= st_ff.ps_stop[p]) begin
				nxt_st.pause[p] = 1'b0;
			end
		end
		// Register bus: answer one cycle after the request
		nxt_st.ack = (avs_read_i || avs_write_i) && !st_ff.ack;
		ri = avs_address_i[5:2];
		wv = 32'h0000_0000;
		case (avs_address_i[8:6])
			3'h0: begin
				case (avs_address_i)
					`SBFF_OFS_FREE: wv = {19'h0_0000, st_ff.free};
					`SBFF_OFS_SEL: wv = {28'h000_0000, st_ff.sel};
					`SBFF_OFS_PUSE: wv = (st_ff.sel < 4'(NPORTS)) ? {19'h0_0000, st_ff.usage[st_ff.sel]} : 32'h0000_0000;
					`SBFF_OFS_TOTTD: wv = {19'h0_0000, st_ff.tot_td};
					`SBFF_OFS_TOTPS: wv = {19'h0_0000, st_ff.tot_ps};
					`SBFF_OFS_TDCNT: wv = {16'h0000, st_ff.tdcnt};
					default: wv = 32'h0000_0000;
				endcase
			end
			`SBFF_GRP_TDLIM: wv = (ri < 4'(NPORTS)) ? {19'h0_0000, st_ff.td_lim[ri]} : 32'h0000_0000;
			`SBFF_GRP_PAUSE: wv = (ri < 4'(NPORTS)) ? {3'h0, st_ff.ps_stop[ri], 3'h0, st_ff.ps_start[ri]} : 32'h0000_0000;
			`SBFF_GRP_MODE: wv = (ri < 4'(NPORTS)) ? {25'h000_0000, st_ff.mode[ri]} : 32'h0000_0000;
			`SBFF_GRP_DCNT: wv = (ri < 4'(NPORTS)) ? {16'h0000, st_ff.dcnt[ri]} : 32'h0000_0000;
			default: wv = 32'h0000_0000;
		endcase
		if (!st_ff.ack) begin
			nxt_st.rdata = avs_read_i ? wv : 32'h0000_0000;
		end
		wv = merge(wv, avs_writedata_i, avs_byteenable_i);
		if (avs_write_i && st_ff.ack) begin
			case (avs_address_i[8:6])
				3'h0: begin
					if (avs_address_i == `SBFF_OFS_SEL) nxt_st.sel = wv[3:0];
					if (avs_address_i == `SBFF_OFS_TOTTD) nxt_st.tot_td = wv[12:0];
					if (avs_address_i == `SBFF_OFS_TOTPS) nxt_st.tot_ps = wv[12:0];
				end
				`SBFF_GRP_TDLIM: if (ri < 4'(NPORTS)) nxt_st.td_lim[ri] = wv[12:0];
				`SBFF_GRP_PAUSE: begin
					if (ri < 4'(NPORTS)) begin
						nxt_st.ps_start[ri] = wv[12:0];
						nxt_st.ps_stop[ri] = wv[`SBFF_PS_STOP_LSB +: 13];
					end
				end
				`SBFF_GRP_MODE: if (ri < 4'(NPORTS)) nxt_st.mode[ri] = wv[6:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !st_ff.ack;
	assign avs_readdata_o = st_ff.rdata;
	assign arr_ready_o = rst_n;
	assign enq_valid_o = st_ff.enq_v;
	assign enq_o = st_ff.enq;
	assign disc_valid_o = st_ff.disc_v;
	assign disc_o = st_ff.disc;
	assign tail_drop_o = st_ff.td;
	assign pause_o = st_ff.pause;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n);

	a_free_bound: assert property (st_ff.free <= `SBFF_PKT_WORDS)
		else $error("free word count above memory size");
	a_alloc_room: assert property (mem_we |-> ext(arr_i.words) <= st_ff.free)
		else $error("allocation exceeded free words");
	a_tail_whole: assert property (tail_drop_o |-> $past(arr_valid_i) && !$past(mem_we))
		else $error("tail dropped frame was also stored");
	a_pause_total: assert property ((|(st_ff.pause & ~$past(st_ff.pause))) |-> $past(used >= st_ff.tot_ps))
		else $error("pause rose below total threshold");
	a_enq_hold: assert property (enq_valid_o && !enq_ready_i |=> enq_valid_o && $stable(enq_o))
		else $error("egress reference changed while stalled");
	a_egr_single: assert property (disc_valid_o && st_ff.cur_egr |-> $onehot(disc_o.mask))
		else $error("egress focused mode discarded several copies");
	a_block_stay: assert property (blk_now |=> $stable(st_ff.head) ##1 st_ff.pend_v[$past(st_ff.src, 2)])
		else $error("blocked frame left its ingress queue");
	a_wrr_serve: assert property (st_ff.fsm == sbff_pkg::SBFF_SEL && (|elig) |=> st_ff.fsm == sbff_pkg::SBFF_LOAD)
		else $error("eligible queue not served");
	a_ing_stat: assert property (ing_inc |-> !st_ff.sw_any && !st_ff.cur_egr)
		else $error("ingress discard counted with switched copies");
	a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("register access not answered in one cycle");
endmodule

//--- test/sbff_analyzer_model.sv
/* Analyzer stand-in: turns a one-cycle request into one arrival with a full result.
 * Assumes requests change just after a rising clk_i edge. */
`timescale 1ns/100ps
module sbff_analyzer_model (
	// Clock and request
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [3:0] port_i,
	input wire logic [14:0] dest_i,
	input wire logic drop_i,
	// Arrival
	output logic arr_valid_o,
	output sbff_pkg::sbff_arr_t arr_o
);
	always_ff @(posedge clk_i) begin
		arr_valid_o <= req_i;
		if (req_i) begin
			arr_o <= '{port: port_i, words: 6'h02, res: '{
				dest_set: dest_i, cpu_queue_mask: 8'h00, mirror: 2'h0, learn_all: 1'b0,
				drop_frame: drop_i, drop_precedence: 2'h3, super_priority_flag: 1'b0, queue_group: 3'h1,
				qos: 3'h7, pcp: 3'h0, class_of_service_id: 3'h5, tc: 3'h2,
				oam_type: 3'h1}};
		end else begin
			// Idle data keeps moving so stale fields cannot pass
			arr_o <= ~arr_o;
		end
	end
endmodule

//--- test/tb_sbff_top.sv
/* Register-driven bench of the frame forwarder: bus tasks, analyzer model, reference monitor.
 * Assumes the bench owns every input of the top module. */
`timescale 1ns/100ps
module tb_sbff_top;
	logic clk_i, rst_n_i, req, drop, rd, wr, rel_valid, enq_ready, arr_valid, enq_valid_o, disc_valid_o, tail_drop_o;
	logic wait_o, arr_ready_o;
	logic [3:0] port, disc_src;
	logic [14:0] dest, cong, pause_o;
	logic [8:0] addr;
	logic [31:0] wdata, rdata, rd_o;
	logic [3:0] egq[$];
	logic [14:0] disc_mask;
	sbff_pkg::sbff_arr_t arr;
	sbff_pkg::sbff_rel_t rel;
	sbff_pkg::sbff_enq_t enq_o, enq_last;
	sbff_pkg::sbff_disc_t disc_o;
	int n_disc, n_td, miscompares, n_tests;

	sbff_analyzer_model sbff_analyzer_model_inst (.clk_i(clk_i), .req_i(req), .port_i(port), .dest_i(dest),
		.drop_i(drop), .arr_valid_o(arr_valid), .arr_o(arr));
	sbff_top sbff_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rd_o),
		.avs_waitrequest_o(wait_o), .arr_valid_i(arr_valid), .arr_i(arr), .arr_ready_o(arr_ready_o),
		.rel_valid_i(rel_valid), .rel_i(rel), .enq_valid_o(enq_valid_o), .enq_o(enq_o),
		.enq_ready_i(enq_ready), .cong_i(cong), .disc_valid_o(disc_valid_o), .disc_o(disc_o),
		.tail_drop_o(tail_drop_o), .pause_o(pause_o));

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		if (enq_valid_o === 1'b1 && enq_ready === 1'b1) begin
			egq.push_back(enq_o.egress);
			enq_last = enq_o;
		end
		if (disc_valid_o === 1'b1) begin
			n_disc++;
			disc_mask = disc_o.mask;
			disc_src = disc_o.src;
		end
		if (tail_drop_o === 1'b1) n_td++;
	end

	task stop_test;
		if (miscompares == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task timeout(input string what);
		miscompares++;
		$display("MISMATCH %s expected done seen timeout", what);
		stop_test;
	endtask

	task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= d;
		// Waitrequest and read data are taken as they stood before the edge
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wait_o === 1'b0) break;
		end
		if (i == 20) timeout("bus");
		rdata = rd_o;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task rchk(input logic [8:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0000_0000);
		chk(what, rdata, exp);
	endtask

	task send(input logic [3:0] p, input logic [14:0] d, input logic dr);
		@(posedge clk_i);
		req <= 1'b1;
		port <= p;
		dest <= d;
		drop <= dr;
		@(posedge clk_i);
		req <= 1'b0;
	endtask

	// Bounded wait for reference and discard totals
	task await(input int ne, input int nd);
		int i;
		for (i = 0; i < 60 && !(egq.size() >= ne && n_disc >= nd); i++) @(posedge clk_i);
		if (i == 60) timeout("forwarder");
		repeat (3) @(posedge clk_i);
	endtask

	initial begin
		{rst_n_i, req, drop, rd, wr, rel_valid, enq_ready, port, dest, cong, addr, wdata} = '0;
		rel = '0;
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		enq_ready <= 1'b1;
		repeat (4) @(posedge clk_i);
		rchk(9'h000, 32'h0000_1740, "free words");
		rchk(9'h100, 32'h0000_1740, "tail limit");
		rchk(9'h140, 32'h0200_0400, "pause levels");
		rchk(9'h180, 32'h0000_0000, "port mode");
		rchk(9'h1FC, 32'h0000_0000, "unmapped");
		chk("arrival ready", arr_ready_o, 32'h0000_0001);
		$display("test reset done");
		bus(1'b1, 9'h004, 32'h0000_0001);
		send(4'h1, 15'h000C, 1'b0);
		await(2, 0);
		chk("egress a", egq[0], 32'h0000_0002);
		chk("egress b", egq[1], 32'h0000_0003);
		chk("ref addr", enq_last.ref_addr, 32'h0000_0004);
		chk("ref source", enq_last.src, 32'h0000_0001);
		chk("ref words", enq_last.words, 32'h0000_0002);
		chk("ref qos", enq_last.qos, 32'h0000_0007);
		chk("ref precedence", enq_last.drop_precedence, 32'h0000_0003);
		chk("ref group", enq_last.queue_group, 32'h0000_0001);
		rchk(9'h008, 32'h0000_0002, "usage");
		rchk(9'h000, 32'h0000_173E, "free used");
		@(posedge clk_i);
		rel_valid <= 1'b1;
		rel <= '{port: 4'h1, words: 6'h02};
		@(posedge clk_i);
		rel_valid <= 1'b0;
		rchk(9'h000, 32'h0000_1740, "free back");
		$display("test forward done");
		cong <= 15'h0004;
		send(4'h0, 15'h0004, 1'b0);
		await(2, 1);
		chk("mask", disc_mask, 32'h0000_0004);
		rchk(9'h1C0, 32'h0000_0001, "ingress count");
		send(4'h0, 15'h0006, 1'b0);
		await(3, 2);
		chk("egress c", egq[2], 32'h0000_0001);
		rchk(9'h1C0, 32'h0000_0001, "count kept");
		$display("test ingress focus done");
		bus(1'b1, 9'h180, 32'h0000_0040);
		cong <= 15'h000C;
		send(4'h0, 15'h000C, 1'b0);
		await(3, 4);
		rchk(9'h1C8, 32'h0000_0001, "egress count 2");
		rchk(9'h1CC, 32'h0000_0001, "egress count 3");
		$display("test egress focus done");
		bus(1'b1, 9'h184, 32'h0000_0008);
		cong <= 15'h0010;
		send(4'h1, 15'h0010, 1'b0);
		send(4'h2, 15'h0020, 1'b0);
		await(4, 4);
		chk("other port", egq[3], 32'h0000_0005);
		chk("blocked", egq.size(), 32'h0000_0004);
		cong <= 15'h0000;
		await(5, 4);
		chk("unblocked", egq[4], 32'h0000_0004);
		cong <= 15'h0010;
		send(4'h1, 15'h0010, 1'b1);
		await(5, 5);
		chk("drop flag", n_disc, 32'h0000_0005);
		chk("discard source", disc_src, 32'h0000_0001);
		$display("test flow control done");
		bus(1'b1, 9'h144, 32'h0000_0002);
		repeat (2) @(posedge clk_i);
		chk("pause on", pause_o, 32'h0000_0002);
		@(posedge clk_i);
		rel_valid <= 1'b1;
		rel <= '{port: 4'h1, words: 6'h02};
		@(posedge clk_i);
		rel_valid <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk("pause off", pause_o, 32'h0000_0000);
		$display("test pause done");
		bus(1'b1, 9'h10C, 32'h0000_0000);
		send(4'h3, 15'h0002, 1'b0);
		repeat (3) @(posedge clk_i);
		chk("tail pulse", n_td, 32'h0000_0001);
		rchk(9'h014, 32'h0000_0001, "tail count");
		chk("no refs", egq.size(), 32'h0000_0005);
		$display("test tail drop done");
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		stop_test;
	end
endmodule
